/* bench/rfd_core_sva.sv */
// Purpose: Port assertions for rfd_core
// Assumes: One clock, nrst async active low
// Notes:   Bound to every rfd_core instance
`timescale 1ns/1ps
`default_nettype none
module rfd_core_sva
  import rfd_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          nrst,
  input wire logic          issue_valid,
  input wire rfd_issue_type issue,
  input wire logic          issue_ready,
  input wire rfd_wb_type    int_wb,
  input wire rfd_wb_type    float_wb,
  input wire rfd_wb_type    data_wb,
  input wire logic          exception_pending,
  input wire logic          supervisor,
  input wire logic          ctl_req,
  input wire logic [2:0]    ctl_slot,
  input wire logic          ctl_grant,
  input wire logic          ctl_fault,
  input wire logic [31:0]   source_bus_b,
  input wire logic          int_grant,
  input wire logic          float_grant,
  input wire logic          data_grant,
  input wire logic          to_int,
  input wire logic          to_data,
  input wire logic          to_float,
  input wire logic          to_float_mul,
  input wire logic [2:0]    to_slot,
  input wire logic          fetch_req,
  input wire logic [31:0]   fetch_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Instruction taken at this edge
  sequence s_take;
    issue_valid && issue_ready;
  endsequence
  property p_int_first;
    int_wb.req && !exception_pending |-> int_grant && !float_grant && !data_grant;
  endproperty
  a_int_first: assert property (p_int_first) else $error("single-cycle result not first");
  property p_float_next;
    float_wb.req && !int_wb.req && !exception_pending |-> float_grant && !data_grant;
  endproperty
  a_float_next: assert property (p_float_next) else $error("float result not second");
  property p_data_last;
    data_wb.req && !int_wb.req && !float_wb.req |-> data_grant;
  endproperty
  a_data_last: assert property (p_data_last) else $error("load result not granted");
  property p_exc_block;
    exception_pending |-> !int_grant && !float_grant;
  endproperty
  a_exc_block: assert property (p_exc_block) else $error("grant during exception");
  property p_imm;
    s_take ##0 issue.use_imm |=> source_bus_b == {16'h0000, $past(issue.imm)};
  endproperty
  a_imm: assert property (p_imm) else $error("immediate not on second bus");
  property p_to_data;
    s_take ##0 (issue.op inside {RFD_OP_LOAD, RFD_OP_STORE}) |=> to_data && !to_float && !to_int;
  endproperty
  a_to_data: assert property (p_to_data) else $error("memory op misrouted");
  property p_to_float;
    s_take ##0 (issue.op inside {RFD_OP_FADD, RFD_OP_DIV, RFD_OP_FMUL, RFD_OP_IMUL})
      |=> to_float && !to_data && to_slot == RFD_FLOAT_SLOT;
  endproperty
  a_to_float: assert property (p_to_float) else $error("float op misrouted");
  property p_mul_pipe;
    s_take ##0 (issue.op inside {RFD_OP_FMUL, RFD_OP_IMUL}) |=> to_float_mul;
  endproperty
  a_mul_pipe: assert property (p_mul_pipe) else $error("multiply not on multiply pipe");
  property p_one_cycle;
    s_take ##0 issue.op == RFD_OP_INT |=> to_int && !to_data && !to_float;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("integer op misrouted");
  property p_ctl;
    ctl_req && !supervisor && ctl_slot == 3'h0 |-> ctl_fault && !ctl_grant;
  endproperty
  a_ctl: assert property (p_ctl) else $error("user access not refused");
  property p_fetch;
    fetch_req && !issue_valid && !$past(issue_valid) |=> fetch_addr == $past(fetch_addr) + RFD_PTR_STEP;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pointer step wrong");
endmodule
bind rfd_core rfd_core_sva rfd_core_sva_i (.clk_sys, .nrst, .issue_valid, .issue, .issue_ready,
  .int_wb, .float_wb, .data_wb, .exception_pending, .supervisor, .ctl_req, .ctl_slot, .ctl_grant,
  .ctl_fault, .source_bus_b, .int_grant, .float_grant, .data_grant, .to_int, .to_data, .to_float,
  .to_float_mul, .to_slot, .fetch_req, .fetch_addr);
`default_nettype wire

/* bench/rfd_units.sv */
// Purpose: Execution units facing rfd_core writeback and fetch
// Assumes: Bench starts requests with one-cycle wb_go pulses
// Notes:   Released results show inverted data, never stale values
`timescale 1ns/1ps
`default_nettype none
module rfd_units
  import rfd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [2:0]  wb_go,     // Start request: int, float, data
  input  wire logic [4:0]  wb_dst,
  input  wire logic [31:0] wb_data,
  input  wire logic [2:0]  wb_grant,  // Grants in the same order
  input  wire logic        fetch_req,
  output rfd_wb_type       int_wb,
  output rfd_wb_type       float_wb,
  output rfd_wb_type       data_wb,
  output logic             fetch_done
);
  rfd_wb_type unit_r [3];  // One pending result per unit
  assign int_wb   = unit_r[0];
  assign float_wb = unit_r[1];
  assign data_wb  = unit_r[2];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      unit_r     <= '{default: '0};
      fetch_done <= 1'b0;
    end else begin
      // Fetch memory answers one cycle later
      fetch_done <= fetch_req;
      for (int i = 0; i < 3; i++) begin
        if (wb_go[i]) begin
          unit_r[i] <= '{1'b1, wb_dst, wb_data};
        end else if (wb_grant[i]) begin
          unit_r[i] <= '{1'b0, ~unit_r[i].dst, ~unit_r[i].data};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb_rfd_core.sv */
// Purpose: Directed bench for rfd_core
// Assumes: Inputs driven by NBA on rising edge
// Notes:   Outputs sampled at falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_rfd_core
  import rfd_pkg::*;
;
  logic          clk_sys = 1'b0;
  logic          nrst = 1'b0;
  logic          issue_valid = 1'b0;
  rfd_issue_type issue = '0;
  logic          exception_pending = 1'b0;
  logic          supervisor = 1'b0;
  logic          ctl_req = 1'b0;
  logic          ctl_write = 1'b0;
  logic [5:0]    ctl_num = 6'h00;
  logic [2:0]    ctl_slot = 3'h0;
  logic          data_retire = 1'b0;
  logic          float_wb_mul = 1'b0;
  logic          float_wb_imul = 1'b0;
  logic [2:0]    wb_go = 3'h0;
  logic [4:0]    wb_dst = 5'h00;
  logic [31:0]   wb_data = 32'h0;
  rfd_wb_type    int_wb, float_wb, data_wb;
  logic          issue_ready, fetch_done, ctl_grant, ctl_fault, int_grant, float_grant, data_grant;
  logic          to_int, to_branch, to_data, to_float, to_float_mul, fetch_req;
  logic [2:0]    to_slot;
  logic [31:0]   source_bus_a, source_bus_b, result_bus, fetch_addr;
  wire  [2:0]    grants = {int_grant, float_grant, data_grant};
  int            failures = 0;
  int            checks = 0;
  int            cycles = 0;

  rfd_core rfd_core_i (.clk_sys, .nrst, .issue_valid, .issue, .issue_ready, .int_wb, .float_wb,
    .float_wb_mul, .float_wb_imul, .data_wb, .data_retire, .fetch_done,
    .exception_pending, .supervisor, .ctl_req, .ctl_write, .ctl_num, .ctl_slot, .ctl_grant,
    .ctl_fault, .source_bus_a, .source_bus_b, .result_bus, .int_grant, .float_grant, .data_grant,
    .to_int, .to_branch, .to_data, .to_float, .to_float_mul, .to_slot, .fetch_req, .fetch_addr);
  rfd_units rfd_units_i (.clk_sys, .nrst, .wb_go, .wb_dst, .wb_data, .wb_grant({data_grant, float_grant, int_grant}),
    .fetch_req, .int_wb, .float_wb, .data_wb, .fetch_done);

  // Clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // Offer an instruction, second operand always the zero register
  task automatic offer(input rfd_op_type op, input logic [4:0] a, input logic [4:0] d,
                       input logic ui, input logic [15:0] imm);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue <= '{op, a, 5'h00, d, ui, imm};
    @(negedge clk_sys);
  endtask
  // Bounded wait for acceptance, then drop the offer
  task automatic take;
    int n;
    n = 0;
    while (issue_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk(issue_ready, 32'h1);
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic issue_op(input rfd_op_type op, input logic [4:0] a, input logic [4:0] d,
                          input logic ui, input logic [15:0] imm);
    offer(op, a, d, ui, imm);
    take;
  endtask
  // Unit results; grants reversed so bit 0 is int
  task automatic wb(input logic [2:0] go, input logic [4:0] d, input logic [31:0] v);
    @(posedge clk_sys);
    wb_go <= go;
    wb_dst <= d;
    wb_data <= v;
    @(posedge clk_sys);
    wb_go <= 3'h0;
    @(negedge clk_sys);
  endtask
  task automatic retire;
    @(posedge clk_sys);
    data_retire <= 1'b1;
    @(posedge clk_sys);
    data_retire <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic ctl(input logic s, input logic w, input logic [5:0] num, input logic g);
    @(posedge clk_sys);
    supervisor <= s;
    ctl_req <= 1'b1;
    ctl_write <= w;
    ctl_num <= num;
    @(negedge clk_sys);
    chk({ctl_grant, ctl_fault}, {30'h0, g, !g});
  endtask

  task automatic t_regs;
    wb(3'h1, 5'h03, 32'h1234_5678);
    wb(3'h1, 5'h00, 32'hffff_ffff);
    chk(result_bus, 32'h1234_5678);
    issue_op(RFD_OP_INT, 5'h03, 5'h07, 1'b0, 16'h0000);
    chk(source_bus_a, 32'h1234_5678);
    chk(source_bus_b, 32'h0);
    issue_op(RFD_OP_INT, 5'h00, 5'h07, 1'b1, 16'h8001);
    chk(source_bus_a, 32'h0);
    chk(source_bus_b, 32'h0000_8001);
    issue_op(RFD_OP_STORE, 5'h00, 5'h03, 1'b1, 16'h0000);
    chk(result_bus, 32'h1234_5678);
    retire;
    $display("test regs done");
  endtask
  task automatic t_prio;
    wb(3'h7, 5'h04, 32'h0000_00a5);
    chk(grants, 32'h4);
    @(negedge clk_sys);
    chk(grants, 32'h2);
    @(negedge clk_sys);
    chk(grants, 32'h1);
    @(posedge clk_sys);
    exception_pending <= 1'b1;
    wb(3'h7, 5'h04, 32'h0000_005a);
    chk(grants, 32'h1);
    @(posedge clk_sys);
    exception_pending <= 1'b0;
    @(negedge clk_sys);
    chk(grants, 32'h4);
    repeat (3) @(negedge clk_sys);
    $display("test prio done");
  endtask
  task automatic t_stall;
    issue_op(RFD_OP_LOAD, 5'h00, 5'h05, 1'b1, 16'h0010);
    offer(RFD_OP_INT, 5'h05, 5'h08, 1'b1, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk(issue_ready, 32'h0);
    wb(3'h4, 5'h05, 32'h0bad_cafe);
    take;
    chk(source_bus_a, 32'h0bad_cafe);
    retire;
    $display("test stall done");
  endtask
  task automatic t_data;
    for (int i = 0; i < 3; i++) begin
      issue_op(RFD_OP_LOAD, 5'h00, 5'(9 + i), 1'b1, 16'h0000);
    end
    offer(RFD_OP_LOAD, 5'h00, 5'h0c, 1'b1, 16'h0000);
    chk(issue_ready, 32'h0);
    retire;
    take;
    repeat (3) retire;
    $display("test data done");
  endtask
  task automatic t_dispatch;
    rfd_op_type op;
    for (int i = 0; i < 8; i++) begin
      op = rfd_op_type'(8'h01 << i);
      issue_op(op, 5'h00, 5'(16 + i), 1'b1, 16'h0000);
      chk(to_int, 32'(op == RFD_OP_INT));
      chk(to_branch, 32'(op == RFD_OP_BRANCH));
      chk(to_data, 32'(i == 2 || i == 3));
      chk(to_float, 32'(i > 3));
      chk(to_float_mul, 32'(i > 5));
      chk(to_slot, (i > 3) ? RFD_FLOAT_SLOT : 3'h0);
    end
    @(posedge clk_sys);
    {float_wb_mul, float_wb_imul} <= 2'b11;
    wb(3'h2, 5'h17, 32'h0000_0123);
    issue_op(RFD_OP_INT, 5'h17, 5'h08, 1'b0, 16'h0000);
    chk(source_bus_a, 32'h0000_0123);
    repeat (2) retire;
    $display("test dispatch done");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk(source_bus_a, 32'h0);
    chk(fetch_req, 32'h1);
    t_regs;
    t_prio;
    t_stall;
    t_data;
    t_dispatch;
    ctl(1'b0, 1'b0, 6'h05, 1'b0);
    ctl(1'b1, 1'b0, 6'h05, 1'b1);
    ctl(1'b1, 1'b1, 6'h00, 1'b0);
    $display("test ctl done");
    stop_test;
  end
endmodule
`default_nettype wire

/* design/rfd_core.sv */
// Purpose: General register file, source and result buses, writeback
//          arbitration, in-use flags and dispatch to the execution units
// Assumes: Execution units hold their results until granted
// Notes:   All state on clk_sys rising edge, nrst async active low
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Three 32-bit buses, two one-way, one two-way
// RULE2: Source buses feed integer, data, instruction, float
// RULE3: Source operand is register or 16-bit immediate
// RULE4: Result bus writes registers, carries store data
// RULE5: Sequencer drives chosen source registers onto buses
// RULE6: Arbiter picks destination; unit raises write request
// RULE7: Up to seven concurrent units; float is slot one
// RULE8: Five operation classes may run at once
// RULE9: Float accepts each clock; 5 add, 6/4 multiplies
// RULE10: Data unit allows three accesses in progress
// RULE11: Up to two instruction fetches outstanding
// RULE12: Memory ops to data, multiply/divide/float to float
// RULE13: Float has multiply pipe and add/divide pipe
// RULE14: Other instructions finish in one cycle
// RULE15: Decode and operand read in same cycle
// RULE16: Branch target computed while next fetch proceeds
// RULE17: Write and read same cycle, even same register
// RULE18: Thirty-two registers; register zero reads zero always
// RULE19: Most control registers supervisor only; some read-only
// RULE20: Pointers and in-use flags are internal only
// RULE21: Three register accesses per cycle without contention
// RULE22: Writeback priority single-cycle, float, data; exception memory-only
// RULE23: Stall while any needed register is in use
// RULE24: Forward result bus onto waiting source bus
// RULE25: Single clock; reset clears flags and valids
module rfd_core
  import rfd_pkg::*;
(
  input  wire logic          clk_sys,         // Processor clock
  input  wire logic          nrst,            // Async reset, active low
  input  wire logic          issue_valid,     // Instruction unit offers a decoded instruction
  input  wire rfd_issue_type issue,           // Decoded instruction fields
  output logic               issue_ready,     // Instruction taken this cycle
  input  wire rfd_wb_type    int_wb,          // Single-cycle result request
  input  wire rfd_wb_type    float_wb,        // Float unit result request
  input  wire logic          float_wb_mul,    // Float result comes from the multiply pipe
  input  wire logic          float_wb_imul,   // That multiply result was an integer multiply
  input  wire rfd_wb_type    data_wb,         // Load result request
  input  wire logic          data_retire,     // Data unit finished one access
  input  wire logic          fetch_done,      // One instruction fetch returned
  input  wire logic          exception_pending, // Exception awaiting recognition
  input  wire logic          supervisor,      // Processor in supervisor mode
  input  wire logic          ctl_req,         // Control register access request
  input  wire logic          ctl_write,       // Control register access is a write
  input  wire logic [5:0]    ctl_num,         // Control register number
  input  wire logic [2:0]    ctl_slot,        // Unit slot owning the control register
  output logic               ctl_grant,       // Control register access allowed
  output logic               ctl_fault,       // Control register access refused
  output logic [31:0]        source_bus_a,    // First source bus
  output logic [31:0]        source_bus_b,    // Second source bus
  output logic [31:0]        result_bus,      // Result bus contents
  output logic               int_grant,       // Writeback granted to single-cycle result
  output logic               float_grant,     // Writeback granted to float unit
  output logic               data_grant,      // Writeback granted to data unit
  output logic               to_int,          // Dispatch pulse to integer unit
  output logic               to_branch,       // Dispatch pulse to branch logic
  output logic               to_data,         // Dispatch pulse to data unit
  output logic               to_float,        // Dispatch pulse to float unit
  output logic               to_float_mul,    // Float dispatch targets the multiply pipe
  output logic [2:0]         to_slot,         // Unit slot of the dispatched instruction
  output logic               fetch_req,       // Request for a new instruction fetch
  output logic [31:0]        fetch_addr       // Address of that fetch
);

  // Register array; entry zero is never written
  logic [31:0] regs_r [RFD_NUM_REGS];
  // In-use flags, one per register
  logic [31:0] in_use_flags_r;
  logic [31:0] in_use_flags_nxt;
  // Internal instruction pointers, no programmer path
  logic [31:0] execute_pointer_r;
  logic [31:0] next_pointer_r;
  logic [31:0] fetch_pointer_r;
  // In-flight counters per pipeline
  logic [2:0]  add_cnt_r;
  logic [2:0]  mul_cnt_r;
  logic [2:0]  imul_cnt_r;
  logic [1:0]  data_cnt_r;
  logic [1:0]  fetch_cnt_r;

  // Granted writeback and its contents
  rfd_wb_type  wb;
  logic        take;
  logic        multi;
  logic        room;
  logic        busy;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] branch_target;

  // Writeback arbiter: fixed priority, memory results only under exception
  always_comb begin
    // RULE22 priority and exception gate
    int_grant   = int_wb.req & ~exception_pending;
    float_grant = float_wb.req & ~exception_pending & ~int_grant;
    data_grant  = data_wb.req & ~int_grant & ~float_grant;
    // RULE6 arbiter selects destination
    if (int_grant) begin
      wb = int_wb;
    end else if (float_grant) begin
      wb = float_wb;
    end else if (data_grant) begin
      wb = data_wb;
    end else begin
      wb = '0;
    end
    wb.req = int_grant | float_grant | data_grant;
  end

  // Operand read with forwarding from the granted result
  function automatic logic [31:0] rd_op(input logic [4:0] idx, input logic [31:0] cur, input rfd_wb_type w);
    logic [31:0] val;
    val = cur;
    // RULE18 zero register
    if (idx == 5'h00) begin
      val = RFD_ZERO_WORD;
    // RULE24 forwarding path
    end else if (w.req && (w.dst == idx)) begin
      val = w.data;
    end
    return val;
  endfunction

  // Operand selection for the two source buses
  always_comb begin
    // RULE15 read in decode cycle
    // RULE21 two reads beside the result bus
    op_a = rd_op(issue.src_a, regs_r[issue.src_a], wb);
    // RULE3 immediate zero-extended onto second bus
    if (issue.use_imm) begin
      op_b = {16'h0000, issue.imm};
    end else begin
      op_b = rd_op(issue.src_b, regs_r[issue.src_b], wb);
    end
  end

  // Issue check: in-use flags and pipeline room
  always_comb begin
    // RULE23 stall on in-use registers; a register freed this cycle counts as free
    busy = 1'b0;
    if (in_use_flags_r[issue.src_a] && !(wb.req && wb.dst == issue.src_a)) begin
      busy = 1'b1;
    end
    if (!issue.use_imm && in_use_flags_r[issue.src_b] && !(wb.req && wb.dst == issue.src_b)) begin
      busy = 1'b1;
    end
    if (in_use_flags_r[issue.dst] && !(wb.req && wb.dst == issue.dst)) begin
      busy = 1'b1;
    end
    // RULE9 per-pipe in-flight limits
    // RULE10 data access limit
    case (issue.op)
      RFD_OP_LOAD, RFD_OP_STORE: room = data_cnt_r < RFD_DATA_MAX;
      RFD_OP_FADD, RFD_OP_DIV:   room = add_cnt_r < RFD_ADD_MAX;
      RFD_OP_FMUL:               room = mul_cnt_r < RFD_FMUL_MAX;
      RFD_OP_IMUL:               room = (mul_cnt_r < RFD_FMUL_MAX) && (imul_cnt_r < RFD_IMUL_MAX);
      default:                   room = 1'b1;
    endcase
    issue_ready = issue_valid & ~busy & room & ~exception_pending;
    take        = issue_ready;
    // RULE14 one-cycle classes and stores skip the flags
    multi = (issue.op != RFD_OP_INT) && (issue.op != RFD_OP_BRANCH) && (issue.op != RFD_OP_STORE);
  end

  // Register array writes; one write port beside two read ports
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < RFD_NUM_REGS; i++) begin
        regs_r[i] <= RFD_ZERO_WORD;
      end
    // RULE17 write while other units read
    // RULE18 writes to zero register dropped
    end else if (wb.req && wb.dst != 5'h00) begin
      regs_r[wb.dst] <= wb.data;
    end
  end

  // In-use flags: cleared by writeback, set by multi-cycle issue
  always_comb begin
    in_use_flags_nxt = in_use_flags_r;
    if (wb.req) begin
      in_use_flags_nxt[wb.dst] = 1'b0;
    end
    // Set wins over a clear of the same register in one cycle
    if (take && multi) begin
      in_use_flags_nxt[issue.dst] = 1'b1;
    end
    // Zero register is never awaited
    in_use_flags_nxt[0] = 1'b0;
  end

  // RULE20 flags kept internal
  // RULE25 reset clears flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_use_flags_r <= RFD_ZERO_WORD;
    end else begin
      in_use_flags_r <= in_use_flags_nxt;
    end
  end

  // Source and result bus registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      source_bus_a <= RFD_ZERO_WORD;
      source_bus_b <= RFD_ZERO_WORD;
      result_bus   <= RFD_ZERO_WORD;
    end else begin
      // RULE1 RULE2 RULE5 operands gated on issue
      if (take) begin
        source_bus_a <= op_a;
        source_bus_b <= op_b;
      end
      // RULE4 results inward, otherwise store data outward
      if (wb.req) begin
        result_bus <= wb.data;
      end else if (take && issue.op == RFD_OP_STORE) begin
        result_bus <= rd_op(issue.dst, regs_r[issue.dst], wb);
      end
    end
  end

  // Dispatch pulses, one cycle after the issue
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      to_int       <= 1'b0;
      to_branch    <= 1'b0;
      to_data      <= 1'b0;
      to_float     <= 1'b0;
      to_float_mul <= 1'b0;
      to_slot      <= 3'h0;
    end else begin
      // RULE14 one-cycle classes
      to_int    <= take && issue.op == RFD_OP_INT;
      to_branch <= take && issue.op == RFD_OP_BRANCH;
      // RULE12 memory to data unit, the rest to float
      to_data   <= take && (issue.op == RFD_OP_LOAD || issue.op == RFD_OP_STORE);
      to_float  <= take && (issue.op == RFD_OP_FADD || issue.op == RFD_OP_DIV ||
                            issue.op == RFD_OP_FMUL || issue.op == RFD_OP_IMUL);
      // RULE13 pipe select inside float unit
      to_float_mul <= take && (issue.op == RFD_OP_FMUL || issue.op == RFD_OP_IMUL);
      // RULE7 float unit is slot one, integer side slot zero
      to_slot   <= (take && issue.op[7:4] != 4'h0) ? RFD_FLOAT_SLOT : 3'h0;
    end
  end

  // Float pipeline occupancy
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      add_cnt_r  <= 3'h0;
      mul_cnt_r  <= 3'h0;
      imul_cnt_r <= 3'h0;
    end else begin
      // RULE8 RULE9 counts let classes overlap
      // A grant with nothing counted is dropped: a wrapped count would
      // look like a full pipe and hold off issue until the next reset
      add_cnt_r <= add_cnt_r + 3'(take && (issue.op == RFD_OP_FADD || issue.op == RFD_OP_DIV))
                             - 3'(float_grant && !float_wb_mul && add_cnt_r != 3'h0);
      mul_cnt_r <= mul_cnt_r + 3'(take && (issue.op == RFD_OP_FMUL || issue.op == RFD_OP_IMUL))
                             - 3'(float_grant && float_wb_mul && mul_cnt_r != 3'h0);
      imul_cnt_r <= imul_cnt_r + 3'(take && issue.op == RFD_OP_IMUL)
                               - 3'(float_grant && float_wb_mul && float_wb_imul
                                    && imul_cnt_r != 3'h0);
    end
  end

  // Data unit occupancy; the unit reports each finished access
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_cnt_r <= 2'h0;
    end else begin
      // RULE10 three accesses at most
      // A retire with nothing in progress is ignored rather than wrapping
      data_cnt_r <= data_cnt_r + 2'(take && (issue.op == RFD_OP_LOAD || issue.op == RFD_OP_STORE))
                               - 2'(data_retire && data_cnt_r != 2'h0);
    end
  end

  // Branch target from the next pointer and the word displacement
  always_comb begin
    // RULE16 computed beside the sequential fetch
    branch_target = next_pointer_r + {{14{issue.imm[15]}}, issue.imm, 2'b00};
  end

  // Fetch requests; stalls when two are already outstanding
  always_comb begin
    // RULE11 two fetches at most
    fetch_req  = fetch_cnt_r < RFD_FETCH_MAX;
    fetch_addr = fetch_pointer_r;
  end

  // Outstanding fetch counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fetch_cnt_r <= 2'h0;
    end else begin
      // A stray return with nothing outstanding is ignored
      // so the count can never wrap and stall fetching
      fetch_cnt_r <= fetch_cnt_r + 2'(fetch_req) - 2'(fetch_done && fetch_cnt_r != 2'h0);
    end
  end

  // Instruction pointers advance with fetch and issue
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      execute_pointer_r <= RFD_RESET_PTR;
      next_pointer_r    <= RFD_RESET_PTR;
      fetch_pointer_r   <= RFD_RESET_PTR;
    end else begin
      // RULE20 pointers have no software path
      if (take) begin
        execute_pointer_r <= next_pointer_r;
        next_pointer_r    <= next_pointer_r + RFD_PTR_STEP;
      end
      if (take && issue.op == RFD_OP_BRANCH) begin
        fetch_pointer_r <= branch_target;
      end else if (fetch_req) begin
        fetch_pointer_r <= fetch_pointer_r + RFD_PTR_STEP;
      end
    end
  end

  // Control register access check
  always_comb begin
    // RULE19 supervisor gate; number zero is identification, read-only
    ctl_fault = ctl_req && ((!supervisor && ctl_slot == 3'h0) ||
                            (ctl_write && ctl_num == 6'h00 && ctl_slot == 3'h0) ||
                            (ctl_slot > RFD_MAX_SFU));
    ctl_grant = ctl_req && !ctl_fault;
  end

endmodule

`default_nettype wire

/* design/rfd_pkg.sv */
// Purpose: Shared types and constants for the register file and dispatch core
// Assumes: Single processor clock, 32-bit datapath
// Notes:   Operation classes steer dispatch and scoreboard handling
package rfd_pkg;

  // Datapath and register file shape
  localparam int unsigned RFD_DATA_W   = 32;
  localparam int unsigned RFD_IMM_W    = 16;
  localparam int unsigned RFD_NUM_REGS = 32;
  localparam int unsigned RFD_IDX_W    = 5;
  localparam int unsigned RFD_SLOT_W   = 3;

  // Special function unit slots
  localparam logic [2:0]  RFD_MAX_SFU    = 3'h7;
  localparam logic [2:0]  RFD_FLOAT_SLOT = 3'h1;

  // In-flight limits per pipeline
  localparam logic [2:0]  RFD_ADD_MAX  = 3'h5;
  localparam logic [2:0]  RFD_FMUL_MAX = 3'h6;
  localparam logic [2:0]  RFD_IMUL_MAX = 3'h4;
  localparam logic [1:0]  RFD_DATA_MAX = 2'h3;
  localparam logic [1:0]  RFD_FETCH_MAX = 2'h2;

  // Reset values and pointer step
  localparam logic [31:0] RFD_ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] RFD_RESET_PTR = 32'h0000_0000;
  localparam logic [31:0] RFD_PTR_STEP  = 32'h0000_0004;

  // Operation classes from the instruction unit decoder
  typedef enum logic [7:0] {
    RFD_OP_INT    = 8'h01,  // Arithmetic, logical, bit-field
    RFD_OP_BRANCH = 8'h02,  // Flow control
    RFD_OP_LOAD   = 8'h04,  // Data memory read
    RFD_OP_STORE  = 8'h08,  // Data memory write
    RFD_OP_FADD   = 8'h10,  // Float add, sub, compare, convert
    RFD_OP_DIV    = 8'h20,  // Integer or float divide
    RFD_OP_FMUL   = 8'h40,  // Float multiply
    RFD_OP_IMUL   = 8'h80   // Integer multiply
  } rfd_op_type;

  // Decoded instruction offered for issue
  typedef struct packed {
    rfd_op_type           op;
    logic [4:0]           src_a;
    logic [4:0]           src_b;
    logic [4:0]           dst;
    logic                 use_imm;
    logic [15:0]          imm;
  } rfd_issue_type;

  // Writeback request from an execution unit
  typedef struct packed {
    logic                 req;
    logic [4:0]           dst;
    logic [31:0]          data;
  } rfd_wb_type;

endpackage
